// >>> design/assgl_defs.vh
// Constants for the supply select, noise gate and supply tracking limiter block
`ifndef ASSGL_DEFS_VH
`define ASSGL_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define ASSGL_OFS_STAGE_EFF 8'h48
`define ASSGL_OFS_REL_THR 8'h6a

// ****************************************
// Supply mode codes
// ****************************************
`define ASSGL_MODE_DUAL 2'b00
`define ASSGL_MODE_HIGH_ONLY 2'b10
`define ASSGL_MODE_DUAL_LOWP 2'b11

// ****************************************
// Level and timing scaling
// ****************************************
`define ASSGL_LOWP_BASE_SHIFT 5'h0c
`define ASSGL_GATE_BASE_SHIFT 5'h10
`define ASSGL_RAIL_MARGIN_MV 32'h00000fa0
`define ASSGL_RTH_STEP_MV 16'h0064
`define ASSGL_HYS_UNIT 20'h00010
`define ASSGL_DLY_UNIT 20'h00004
`define ASSGL_GATE_HYS_UNIT 20'h00100
`define ASSGL_HOLD_UNIT 20'h00040
`define ASSGL_REL_UNIT 20'h00008
`define ASSGL_PIPE_DEPTH 20'h00007
`define ASSGL_SLOPE_ONE 32'h00000100

`endif

// >>> design/assgl_top.v
// Supply rail select, bypass line, noise gate and supply tracking limiter
// What this block does
// - Below fixed threshold longer than hysteresis moves output stage to the low rail.
// - Bypass line is released only after the remaining samples have been output.
// - Bypass asserted means released open drain; de-asserted means driven low.
// - On rising level, drive bypass low after its delay, high rail after switch delay.
// - Relative mode picks low rail when output below low rail times efficiency minus threshold.
// - Mode 11 uses low-power two-bit threshold; mode 00 uses five-bit fixed threshold.
// - Mode 00 dual switching, 10 high rail only, 11 low rail near idle.
// - Outside dual switching, output stage uses only the selected supply, clipping or not.
// - In high-rail-only mode, source bit picks external low rail or internal regulator.
// - High rail below low rail plus 4 V stops switching and holds high rail.
// - Gate enabled powers stage down after input stays below level past hysteresis.
// - Gate re-powers stage 7 samples before those samples reach the bridge.
// - Volume ramping applies on gate transitions while ramp disable is low.
// - Fine gate mode uses 32-bit fine level and fine hysteresis bits 18 to 3.
// - Gate active disables converter and processor, holds readings, zeroes sent monitor samples.
// - Total attenuation is capped at the device attenuation cap.
// - Brownout engaged pauses limiter gain alignment until fully released.
// - Combine mode picks sum or larger of limiter and brownout attenuation.
// - Enabled limiter reduces gain above threshold using attack, hold and release fields.
// - While attacking, limiter stops at its attenuation cap.
// - Threshold is top above knee, drops by slope below, never under floor.
// - Headroom mode sets peak output to high rail scaled by signed percent.
// - Pause bit set freezes limiter updates from brownout until full release.
`include "assgl_defs.vh"

module assgl_top #(
  parameter SW = 24
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Audio sample stream and measured levels
  input wire sample_valid,
  input wire [SW-1:0] sample_in,
  input wire [31:0] out_level_mv,
  input wire [31:0] high_rail_mv,
  input wire [31:0] low_rail_mv,
  // Supply selection settings
  input wire [1:0] supply_mode,
  input wire low_rail_source,
  input wire [4:0] fixed_level_threshold,
  input wire [1:0] low_power_fixed_threshold,
  input wire [3:0] rail_drop_hysteresis,
  input wire [1:0] bypass_release_delay,
  input wire [1:0] supply_switch_delay,
  input wire relative_threshold_mode,
  input wire [7:0] relative_rail_threshold,
  input wire [31:0] output_stage_efficiency,
  // Noise gate settings
  input wire gate_enable,
  input wire [1:0] gate_level,
  input wire [1:0] gate_hysteresis,
  input wire gate_ramp_disable,
  input wire gate_fine_enable,
  input wire [31:0] gate_fine_level,
  input wire [15:0] gate_fine_hysteresis,
  // Limiter settings
  input wire limiter_enable,
  input wire [3:0] limiter_attack_rate,
  input wire [2:0] limiter_hold_time,
  input wire [3:0] limiter_release_rate,
  input wire [3:0] limiter_attenuation_cap,
  input wire [31:0] limiter_threshold_top,
  input wire [31:0] limiter_knee_voltage,
  input wire [31:0] limiter_tracking_slope,
  input wire [31:0] limiter_threshold_floor,
  input wire headroom_mode_enable,
  input wire [4:0] headroom_percent,
  input wire limiter_pause_on_brownout,
  input wire gain_combine_mode,
  input wire [6:0] device_attenuation_cap,
  // Brownout engine status
  input wire brownout_active,
  input wire [6:0] brownout_atten,
  // Monitor converter readings
  input wire [15:0] monitor_in,
  // Bridge side
  output reg [SW-1:0] bridge_sample,
  output reg bridge_valid,
  output reg low_rail_select,
  output reg ldo_enable,
  output reg stage_power_on,
  output reg volume_ramp_en,
  // Open-drain bypass line
  output reg bypass_enable_line_o,
  output reg bypass_enable_line_oe,
  // Monitor and processor control
  output reg monitor_enable,
  output reg [15:0] monitor_held,
  output reg [15:0] tdm_monitor,
  // Attenuation
  output reg [6:0] aligned_limiter_attenuation,
  output reg [6:0] aligned_brownout_attenuation,
  output reg [6:0] applied_attenuation
);

  // ****************************************
  // Supply selection states
  // ****************************************
  localparam S_HIGH = 2'h0;
  localparam S_DRAIN = 2'h1;
  localparam S_LOW = 2'h2;
  localparam S_RISE = 2'h3;

  // Full scale shifted down by 6 dB steps
  function [SW-1:0] level_thr;
    input [4:0] steps;
    begin
      level_thr = {1'b0, {(SW-1){1'b1}}} >> steps;
    end
  endfunction

  // ****************************************
  // Level detection
  // ****************************************
  wire [SW-1:0] abs_level = sample_in[SW-1] ? (~sample_in + 1'b1) : sample_in;
  wire [63:0] eff_prod = low_rail_mv * output_stage_efficiency;
  wire [31:0] rel_sub = {16'h0000, `ASSGL_RTH_STEP_MV} * {28'h0000000, relative_rail_threshold[3:0]};
  wire [31:0] rel_limit = (eff_prod[47:16] > rel_sub) ? (eff_prod[47:16] - rel_sub) : 32'h00000000;
  wire [4:0] fix_steps = (supply_mode == `ASSGL_MODE_DUAL_LOWP) ?
                         (`ASSGL_LOWP_BASE_SHIFT + {3'b000, low_power_fixed_threshold}) :
                         fixed_level_threshold;
  wire rail_below = relative_threshold_mode ? (out_level_mv < rel_limit) :
                    (abs_level < level_thr(fix_steps));
  wire rail_ok = high_rail_mv >= (low_rail_mv + `ASSGL_RAIL_MARGIN_MV);
  wire dual_mode = (supply_mode == `ASSGL_MODE_DUAL) || (supply_mode == `ASSGL_MODE_DUAL_LOWP);
  wire allow_low = dual_mode && rail_ok;

  // Sample-period counts for the supply path
  wire [19:0] hys_cnt = ({16'h0000, rail_drop_hysteresis} + 20'h00001) * `ASSGL_HYS_UNIT;
  wire [19:0] byp_cnt = {18'h00000, bypass_release_delay} * `ASSGL_DLY_UNIT;
  wire [19:0] cds_cnt = {18'h00000, supply_switch_delay} * `ASSGL_DLY_UNIT;

  // ****************************************
  // Output delay line
  // ****************************************
  reg [SW-1:0] dly_mem [0:`ASSGL_PIPE_DEPTH-1];

  // First stage of the delay line
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dly_mem[0] <= {SW{1'b0}};
    else if (sample_valid)
      dly_mem[0] <= sample_in;
  end

  // Remaining stages shift once per sample
  genvar gi;
  generate
    for (gi = 1; gi < `ASSGL_PIPE_DEPTH; gi = gi + 1)
    begin : g_dly
      always @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          dly_mem[gi] <= {SW{1'b0}};
        else if (sample_valid)
          dly_mem[gi] <= dly_mem[gi-1];
      end
    end
  endgenerate

  // Bridge output takes the oldest sample
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bridge_sample <= {SW{1'b0}};
      bridge_valid <= 1'b0;
    end
    else
    begin
      bridge_valid <= sample_valid;
      if (sample_valid)
        bridge_sample <= dly_mem[`ASSGL_PIPE_DEPTH-1];
    end
  end

  // ****************************************
  // Supply rail and bypass line control
  // ****************************************
  reg [1:0] sup_state_r;
  reg [19:0] sup_cnt_r;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sup_state_r <= S_HIGH;
      sup_cnt_r <= 20'h00000;
      low_rail_select <= 1'b0;
      bypass_enable_line_o <= 1'b0;
      bypass_enable_line_oe <= 1'b1;
      ldo_enable <= 1'b0;
    end
    else
    begin
      bypass_enable_line_o <= 1'b0; // Open drain only ever drives low
      ldo_enable <= (supply_mode == `ASSGL_MODE_HIGH_ONLY) && low_rail_source;
      if (!allow_low)
      begin
        // No switching or too little margin: high rail, line held low
        sup_state_r <= S_HIGH;
        sup_cnt_r <= 20'h00000;
        low_rail_select <= 1'b0;
        bypass_enable_line_oe <= 1'b1;
      end
      else if (sample_valid)
      begin
        case (sup_state_r)
          S_HIGH:
          begin
            if (allow_low && rail_below)
            begin
              if (sup_cnt_r + 20'h00001 > hys_cnt)
              begin
                low_rail_select <= 1'b1;
                sup_state_r <= S_DRAIN;
                sup_cnt_r <= 20'h00000;
              end
              else
                sup_cnt_r <= sup_cnt_r + 20'h00001;
            end
            else
              sup_cnt_r <= 20'h00000;
          end
          S_DRAIN:
          begin
            if (!allow_low || !rail_below)
            begin
              sup_state_r <= S_RISE;
              sup_cnt_r <= 20'h00000;
            end
            else if (sup_cnt_r + 20'h00001 >= `ASSGL_PIPE_DEPTH)
            begin
              bypass_enable_line_oe <= 1'b0; // Release after samples drain
              sup_state_r <= S_LOW;
            end
            else
              sup_cnt_r <= sup_cnt_r + 20'h00001;
          end
          S_LOW:
          begin
            if (!allow_low || !rail_below)
            begin
              sup_state_r <= S_RISE;
              sup_cnt_r <= 20'h00000;
            end
          end
          S_RISE:
          begin
            if (sup_cnt_r >= byp_cnt)
              bypass_enable_line_oe <= 1'b1;
            if (sup_cnt_r >= cds_cnt)
              low_rail_select <= 1'b0;
            if ((sup_cnt_r >= byp_cnt) && (sup_cnt_r >= cds_cnt))
            begin
              sup_state_r <= S_HIGH;
              sup_cnt_r <= 20'h00000;
            end
            else
              sup_cnt_r <= sup_cnt_r + 20'h00001;
          end
          default:
          begin
            sup_state_r <= S_HIGH;
            sup_cnt_r <= 20'h00000;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Noise gate
  // ****************************************
  reg gate_active_r;
  reg [19:0] gate_cnt_r;
  wire [4:0] gate_steps = `ASSGL_GATE_BASE_SHIFT + {3'b000, gate_level};
  wire [31:0] abs_ext = {{(32-SW){1'b0}}, abs_level};
  wire gate_below = gate_fine_enable ? (abs_ext < gate_fine_level) :
                    (abs_level < level_thr(gate_steps));
  wire [19:0] gate_hys_cnt = gate_fine_enable ? {1'b0, gate_fine_hysteresis, 3'b000} :
                             ({18'h00000, gate_hysteresis} + 20'h00001) * `ASSGL_GATE_HYS_UNIT;

  // Gate state after this edge; monitor control follows it in the same cycle
  wire gate_trip = sample_valid && gate_below && !gate_active_r && (gate_cnt_r + 20'h00001 > gate_hys_cnt);
  wire gate_wake = !gate_enable || (sample_valid && !gate_below);
  wire gate_active_nxt = gate_enable && (gate_trip || (gate_active_r && !gate_wake));

  // Gate state and its hysteresis counter
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gate_active_r <= 1'b0;
      gate_cnt_r <= 20'h00000;
      stage_power_on <= 1'b1;
      volume_ramp_en <= 1'b0;
    end
    else
    begin
      gate_active_r <= gate_active_nxt;
      // Power returns as the waking sample enters the delay line, ahead of the bridge
      stage_power_on <= !gate_active_nxt;
      volume_ramp_en <= gate_enable && (gate_active_nxt != gate_active_r) && !gate_ramp_disable;
      if (gate_wake)
        gate_cnt_r <= 20'h00000;
      else if (sample_valid && !gate_active_r && !gate_trip)
        gate_cnt_r <= gate_cnt_r + 20'h00001;
    end
  end

  // Monitor converter hold and zeroed transmit while gated
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      monitor_enable <= 1'b1;
      monitor_held <= 16'h0000;
      tdm_monitor <= 16'h0000;
    end
    else
    begin
      monitor_enable <= !gate_active_nxt;
      if (!gate_active_nxt)
        monitor_held <= monitor_in;
      tdm_monitor <= gate_active_nxt ? 16'h0000 : monitor_in;
    end
  end

  // ****************************************
  // Limiter threshold
  // ****************************************
  wire [31:0] knee_drop = limiter_knee_voltage - high_rail_mv;
  wire [63:0] slope_prod = knee_drop * limiter_tracking_slope;
  wire [31:0] track_red = slope_prod[39:8];
  wire [31:0] track_span = (limiter_threshold_top > limiter_threshold_floor) ?
                           (limiter_threshold_top - limiter_threshold_floor) : 32'h00000000;
  wire [31:0] track_thr = (high_rail_mv >= limiter_knee_voltage) ? limiter_threshold_top :
                          (track_red >= track_span) ? limiter_threshold_floor :
                          (limiter_threshold_top - track_red);
  wire [7:0] hr_scale = 8'h64 - {{3{headroom_percent[4]}}, headroom_percent};
  wire [39:0] hr_prod = high_rail_mv * hr_scale;
  wire [39:0] hr_div = hr_prod / 40'h64;
  wire [31:0] lim_thr = headroom_mode_enable ? hr_div[31:0] : track_thr;
  wire lim_over = out_level_mv > lim_thr;

  // Limiter pause while brownout holds priority
  wire lim_pause = brownout_active && limiter_pause_on_brownout;
  wire [15:0] atk_cnt = {12'h000, limiter_attack_rate} + 16'h0001;
  wire [19:0] hold_cnt = {17'h00000, limiter_hold_time} * `ASSGL_HOLD_UNIT;
  wire [19:0] rls_cnt = ({16'h0000, limiter_release_rate} + 20'h00001) * `ASSGL_REL_UNIT;

  // ****************************************
  // Limiter attenuation
  // ****************************************
  reg [6:0] lim_attn_r;
  reg [19:0] lim_rate_r;
  reg [19:0] lim_hold_r;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lim_attn_r <= 7'h00;
      lim_rate_r <= 20'h00000;
      lim_hold_r <= 20'h00000;
    end
    else if (!limiter_enable)
    begin
      lim_attn_r <= 7'h00;
      lim_rate_r <= 20'h00000;
      lim_hold_r <= 20'h00000;
    end
    else if (sample_valid && !lim_pause)
    begin
      if (lim_over)
      begin
        // Attack one step per attack period, stop at the cap
        lim_hold_r <= hold_cnt;
        if (lim_rate_r[15:0] + 16'h0001 >= atk_cnt)
        begin
          lim_rate_r <= 20'h00000;
          if (lim_attn_r < {3'b000, limiter_attenuation_cap})
            lim_attn_r <= lim_attn_r + 7'h01;
        end
        else
          lim_rate_r <= lim_rate_r + 20'h00001;
      end
      else if (lim_hold_r != 20'h00000)
      begin
        lim_hold_r <= lim_hold_r - 20'h00001;
        lim_rate_r <= 20'h00000;
      end
      else if (lim_attn_r != 7'h00)
      begin
        // Release one step per release period
        if (lim_rate_r + 20'h00001 >= rls_cnt)
        begin
          lim_rate_r <= 20'h00000;
          lim_attn_r <= lim_attn_r - 7'h01;
        end
        else
          lim_rate_r <= lim_rate_r + 20'h00001;
      end
    end
  end

  // ****************************************
  // Attenuation combine and cap
  // ****************************************
  wire [7:0] attn_sum = {1'b0, aligned_limiter_attenuation} + {1'b0, aligned_brownout_attenuation};
  wire [7:0] attn_max = (aligned_limiter_attenuation > aligned_brownout_attenuation) ?
                        {1'b0, aligned_limiter_attenuation} : {1'b0, aligned_brownout_attenuation};
  wire [7:0] attn_pick = gain_combine_mode ? attn_max : attn_sum;

  // Aligned values; limiter alignment frozen during brownout
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aligned_limiter_attenuation <= 7'h00;
      aligned_brownout_attenuation <= 7'h00;
      applied_attenuation <= 7'h00;
    end
    else
    begin
      if (!brownout_active)
        aligned_limiter_attenuation <= lim_attn_r;
      aligned_brownout_attenuation <= brownout_atten;
      applied_attenuation <= (attn_pick > {1'b0, device_attenuation_cap}) ?
                             device_attenuation_cap : attn_pick[6:0];
    end
  end

endmodule // assgl_top

// >>> tb/assgl_bypass_partner.sv
// Model of the shared open-drain bypass line, its pull-up and one sibling amplifier
module assgl_bypass_partner (
  // Device pins
  input wire logic dev_o,
  input wire logic dev_oe,
  // Sibling amplifier that still needs the high rail
  input wire logic sibling_hold_low,
  // Resolved line level
  output logic line_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Wired line
  // ****************************************
  // Pull-up wins unless some party drives the line low
  assign line_level = ((dev_oe && !dev_o) || sibling_hold_low) ? 1'b0 : 1'b1;
endmodule // assgl_bypass_partner

// >>> tb/assgl_chk.sv
// Concurrent checks on the supply select, noise gate and attenuation ports
module assgl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs watched
  input wire logic sample_valid,
  input wire logic [1:0] supply_mode,
  input wire logic low_rail_source,
  input wire logic [31:0] high_rail_mv,
  input wire logic [31:0] low_rail_mv,
  input wire logic gain_combine_mode,
  input wire logic [6:0] device_attenuation_cap,
  // Outputs watched
  input wire logic bridge_valid,
  input wire logic low_rail_select,
  input wire logic ldo_enable,
  input wire logic stage_power_on,
  input wire logic bypass_enable_line_o,
  input wire logic bypass_enable_line_oe,
  input wire logic monitor_enable,
  input wire logic [15:0] monitor_held,
  input wire logic [15:0] tdm_monitor,
  input wire logic [6:0] aligned_limiter_attenuation,
  input wire logic [6:0] aligned_brownout_attenuation,
  input wire logic [6:0] applied_attenuation
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] comb_nxt;
  logic [6:0] comb_r;
  // ****************************************
  // Expected applied attenuation
  // ****************************************
  always_comb
  begin
    if (gain_combine_mode)
      comb_nxt = (aligned_limiter_attenuation > aligned_brownout_attenuation) ?
        {1'b0, aligned_limiter_attenuation} : {1'b0, aligned_brownout_attenuation};
    else
      comb_nxt = aligned_limiter_attenuation + aligned_brownout_attenuation;
    if (comb_nxt > {1'b0, device_attenuation_cap})
      comb_nxt = {1'b0, device_attenuation_cap};
  end
  // Registered like the design's output
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      comb_r <= 7'h00;
    else
      comb_r <= comb_nxt[6:0];
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_od_low_only:
    assert property (bypass_enable_line_o == 1'b0) else $error("bypass data not low");
  a_high_only_mode:
    assert property (supply_mode == 2'b10 |=> !low_rail_select && bypass_enable_line_oe)
    else $error("high rail only mode left the high rail");
  a_ldo_source:
    assert property (supply_mode == 2'b10 |=> ldo_enable == $past(low_rail_source)) else $error("regulator select wrong");
  a_rail_margin_hold:
    assert property (supply_mode == 2'b00 && high_rail_mv < low_rail_mv + 32'h00000fa0 |=> !low_rail_select)
    else $error("low rail chosen without margin");
  a_rail_drop_sample:
    assert property ($rose(low_rail_select) |-> $past(sample_valid)) else $error("rail moved off a sample");
  a_release_after_low:
    assert property ($fell(bypass_enable_line_oe) |-> low_rail_select && $past(sample_valid))
    else $error("bypass released before low rail");
  a_gate_monitor_off:
    assert property (!stage_power_on |-> !monitor_enable && tdm_monitor == 16'h0000) else $error("monitor live while gated");
  a_gate_held_stable:
    assert property (!stage_power_on && $past(!stage_power_on) |-> $stable(monitor_held)) else $error("held reading moved");
  a_wake_on_sample:
    assert property ($rose(stage_power_on) |-> $past(sample_valid)) else $error("stage woke off a sample");
  a_atten_combine:
    assert property (applied_attenuation == comb_r) else $error("applied attenuation wrong");
  a_bridge_pace:
    assert property (bridge_valid |-> $past(sample_valid)) else $error("bridge strobe without sample");
endmodule // assgl_chk

bind assgl_top assgl_chk chk (.*);

// >>> tb/tb.sv
// Self-checking testbench for the supply select, noise gate and attenuation block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, sample_valid = 1'b0, low_rail_source = 1'b0, relative_threshold_mode = 1'b0;
  logic [23:0] sample_in = 24'h000000;
  logic [31:0] out_level_mv = 32'h00000000, high_rail_mv = 32'h00002ee0, low_rail_mv = 32'h00000e74;
  logic [1:0] supply_mode = 2'b11, low_power_fixed_threshold = 2'h0, bypass_release_delay = 2'h0;
  logic [1:0] supply_switch_delay = 2'h0, gate_level = 2'h0, gate_hysteresis = 2'h0;
  logic [4:0] fixed_level_threshold = 5'h01, headroom_percent = 5'h00;
  logic [3:0] rail_drop_hysteresis = 4'h0, limiter_attack_rate = 4'h0, limiter_release_rate = 4'h0;
  logic [3:0] limiter_attenuation_cap = 4'h0;
  logic [2:0] limiter_hold_time = 3'h0;
  logic [7:0] relative_rail_threshold = 8'h00;
  logic [31:0] output_stage_efficiency = 32'h00010000, gate_fine_level = 32'h00000100;
  logic [31:0] limiter_threshold_top = 32'h00002710, limiter_knee_voltage = 32'h00000bb8;
  logic [31:0] limiter_tracking_slope = 32'h00000100, limiter_threshold_floor = 32'h000003e8;
  logic gate_enable = 1'b0, gate_ramp_disable = 1'b0, gate_fine_enable = 1'b0, limiter_enable = 1'b0;
  logic headroom_mode_enable = 1'b0, limiter_pause_on_brownout = 1'b0, gain_combine_mode = 1'b0;
  logic brownout_active = 1'b0, sibling_hold_low = 1'b0, ramp_seen = 1'b0;
  logic [15:0] gate_fine_hysteresis = 16'h0002, monitor_in = 16'h1234, held;
  logic [6:0] device_attenuation_cap = 7'h7f, brownout_atten = 7'h00;
  logic [6:0] aligned_limiter_attenuation, aligned_brownout_attenuation, applied_attenuation;
  logic [23:0] bridge_sample;
  logic bridge_valid, low_rail_select, ldo_enable, stage_power_on, volume_ramp_en, monitor_enable;
  logic bypass_enable_line_o, bypass_enable_line_oe, bypass_line;
  logic [15:0] monitor_held, tdm_monitor;
  int err_total = 0;
  int check_count = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  assgl_top #(.SW(24)) uut (.*);

  assgl_bypass_partner partner (.dev_o(bypass_enable_line_o), .dev_oe(bypass_enable_line_oe), .sibling_hold_low,
    .line_level(bypass_line));

  // ****************************************
  // Tasks
  // ****************************************
  // Send n samples, one every two cycles, noting any ramp pulse
  task automatic send(input logic [23:0] s, input int n);
    repeat (n)
    begin
      sample_valid = 1'b1;
      sample_in = s;
      @(negedge clk);
      sample_valid = 1'b0;
      ramp_seen = ramp_seen | volume_ramp_en;
      @(negedge clk);
    end
  endtask

  // Compare one observed value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #400000;
    err_total++;
    give_verdict();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    chk("bypass oe after reset", 1, bypass_enable_line_oe);
    // Mid level stays high in low-power mode, drops in dual mode
    for (int i = 0; i < 2; i++)
    begin
      supply_mode = i ? 2'b00 : 2'b11;
      send(24'h001000, 16);
      chk("rail before hysteresis", 0, low_rail_select);
      send(24'h001000, 1);
      chk("rail after hysteresis", i, low_rail_select);
    end
    send(24'h000100, 6);
    chk("bypass while draining", 1, bypass_enable_line_oe);
    send(24'h000100, 1);
    chk("bypass after drain", 0, bypass_enable_line_oe);
    chk("released line level", 1, bypass_line);
    sibling_hold_low = 1'b1;
    #1 chk("line held by sibling", 0, bypass_line);
    sibling_hold_low = 1'b0;
    bypass_release_delay = 2'h1;
    supply_switch_delay = 2'h2;
    send(24'h7fffff, 3);
    chk("bypass early in delay", 0, bypass_enable_line_oe);
    chk("rail early in delay", 1, low_rail_select);
    send(24'h7fffff, 3);
    chk("bypass after its delay", 1, bypass_enable_line_oe);
    chk("rail before switch delay", 1, low_rail_select);
    send(24'h7fffff, 4);
    chk("rail after switch delay", 0, low_rail_select);
    $display("test rail switching done");
    // High rail only, both low rail sources
    supply_mode = 2'b10;
    for (int i = 0; i < 2; i++)
    begin
      low_rail_source = i[0];
      send(24'h000100, 20);
      chk("rail in high only", 0, low_rail_select);
      chk("regulator enable", i, ldo_enable);
    end
    // Too little headroom between rails keeps the high rail
    supply_mode = 2'b00;
    high_rail_mv = 32'h00001388;
    send(24'h000100, 20);
    chk("rail with low margin", 0, low_rail_select);
    high_rail_mv = 32'h00002ee0;
    // Relative threshold mode
    relative_threshold_mode = 1'b1;
    relative_rail_threshold = 8'h05;
    out_level_mv = 32'h00000c1c;
    send(24'h7fffff, 17);
    chk("rail in relative mode", 1, low_rail_select);
    relative_threshold_mode = 1'b0;
    supply_mode = 2'b10;
    $display("test supply modes done");
    // Coarse noise gate
    gate_enable = 1'b1;
    ramp_seen = 1'b0;
    send(24'h000010, 256);
    chk("stage before gate hysteresis", 1, stage_power_on);
    send(24'h000010, 1);
    chk("stage after gate hysteresis", 0, stage_power_on);
    chk("ramp on gate entry", 1, ramp_seen);
    chk("tdm monitor gated", 0, tdm_monitor);
    held = monitor_held;
    monitor_in = 16'h5678;
    send(24'h000010, 2);
    chk("held monitor", held, monitor_held);
    send(24'h000400, 1);
    chk("stage woken", 1, stage_power_on);
    send(24'h000000, 7);
    chk("wake sample at bridge", 24'h000400, bridge_sample);
    // Fine noise gate
    gate_fine_enable = 1'b1;
    send(24'h000400, 1);
    send(24'h000080, 16);
    chk("stage before fine hysteresis", 1, stage_power_on);
    send(24'h000080, 1);
    chk("stage after fine hysteresis", 0, stage_power_on);
    gate_enable = 1'b0;
    send(24'h000400, 2);
    $display("test noise gate done");
    // Limiter attack up to its cap
    limiter_enable = 1'b1;
    limiter_attenuation_cap = 4'h5;
    out_level_mv = 32'h00002000;
    send(24'h000400, 4);
    chk("limiter below threshold", 0, aligned_limiter_attenuation);
    out_level_mv = 32'h00003000;
    send(24'h000400, 8);
    chk("limiter at cap", 5, aligned_limiter_attenuation);
    out_level_mv = 32'h00000000;
    // Brownout attenuation, both combine modes, with and without the cap
    brownout_active = 1'b1;
    brownout_atten = 7'h14;
    for (int i = 0; i < 4; i++)
    begin
      gain_combine_mode = i[0];
      device_attenuation_cap = i[1] ? 7'h0a : 7'h7f;
      send(24'h000400, 3);
      chk("limiter paused", 5, aligned_limiter_attenuation);
      chk("applied attenuation", i[1] ? 7'h0a : (i[0] ? 7'h14 : 7'h19), applied_attenuation);
    end
    $display("test attenuation done");
    give_verdict();
  end
endmodule // tb
